// *** lane_count.sv ***
`timescale 1ns/1ps
// Counts the set bits of a strobe vector.
module lane_count #(
  parameter int WIDTH = 3,
  parameter int CNT_W = 2
) (
  input wire logic [WIDTH-1:0] lanes_i,
  output logic [CNT_W-1:0] count_o
);
  always_comb
  begin
    count_o = '0;
    for (int i = 0; i < WIDTH; i++)
    begin
      count_o = count_o + CNT_W'(lanes_i[i]);
    end
  end
endmodule

// *** perf_event_select_decode.sv ***
`timescale 1ns/1ps
`include "perf_sel_defs.svh"
// Overview of operation
// - Dispatch event with masks 08H/10H/20H counts cycles port 3/4/5 dispatches.
// - Per-port events add at most one per cycle; software uses counter zero.
// - AAH/01H counts every decoded instruction, even never executed or retired.
// - AAH/08H counts complex instructions decoded; at most one per cycle.
// - ABH/01H counts explicit stack pointer use after implicit change.
// - ABH/02H counts stack pointer additions done by the decoder itself.
// - B0H/00H counts all SIMD micro-ops except 64/32-bit register-to-memory moves.
// - B1H/00H counts saturating SIMD micro-ops as they execute.
// - B3H masks 01H/02H/04H select multiply, shift and pack micro-ops.
// - B3H masks 08H/10H select unpack and logical micro-ops.
module perf_event_select_decode
  import perf_sel_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] event_num_i,
  input wire logic [7:0] unit_mask_i,
  input wire logic port3_dispatch_i,
  input wire logic port4_dispatch_i,
  input wire logic port5_dispatch_i,
  input wire logic [`DECODE_WIDTH-1:0] decoded_i,
  input wire logic complex_decoded_i,
  input wire logic stack_pointer_sync_i,
  input wire logic stack_pointer_auto_add_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_exec_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_move_store_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_saturating_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_multiply_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_shift_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_pack_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_unpack_i,
  input wire logic [`SIMD_WIDTH-1:0] simd_logical_i,
  output logic [`INC_W-1:0] increment_o,
  output logic event_valid_o
);
  event_sel_e selected;
  event_sel_e next_selected;
  logic [`DECODE_CNT_W-1:0] decoded_count;
  logic [`SIMD_CNT_W-1:0] simd_count;
  logic [`SIMD_CNT_W-1:0] sel_simd_count;
  logic [`SIMD_WIDTH-1:0] simd_lanes;
  logic [`INC_W-1:0] next_increment;

  // Decode runs every cycle so a reprogrammed pair takes effect one cycle later.
  always_comb
  begin
    next_selected = sel_none;
    if (event_num_i == `EVT_DISPATCH_PORT && unit_mask_i == `UM_PORT3)
      next_selected = sel_port3;
    else if (event_num_i == `EVT_DISPATCH_PORT && unit_mask_i == `UM_PORT4)
      next_selected = sel_port4;
    else if (event_num_i == `EVT_DISPATCH_PORT && unit_mask_i == `UM_PORT5)
      next_selected = sel_port5;
    else if (event_num_i == `EVT_DECODE && unit_mask_i == `UM_DECODED)
      next_selected = sel_decoded;
    else if (event_num_i == `EVT_DECODE && unit_mask_i == `UM_COMPLEX)
      next_selected = sel_complex;
    else if (event_num_i == `EVT_STACK_PTR && unit_mask_i == `UM_SP_SYNC)
      next_selected = sel_sp_sync;
    else if (event_num_i == `EVT_STACK_PTR && unit_mask_i == `UM_SP_ADDS)
      next_selected = sel_sp_adds;
    else if (event_num_i == `EVT_SIMD_ALL && unit_mask_i == `UM_NONE)
      next_selected = sel_simd_all;
    else if (event_num_i == `EVT_SIMD_SAT && unit_mask_i == `UM_NONE)
      next_selected = sel_simd_sat;
    else if (event_num_i == `EVT_SIMD_TYPE && unit_mask_i == `UM_SIMD_MUL)
      next_selected = sel_simd_mul;
    else if (event_num_i == `EVT_SIMD_TYPE && unit_mask_i == `UM_SIMD_SHIFT)
      next_selected = sel_simd_shift;
    else if (event_num_i == `EVT_SIMD_TYPE && unit_mask_i == `UM_SIMD_PACK)
      next_selected = sel_simd_pack;
    else if (event_num_i == `EVT_SIMD_TYPE && unit_mask_i == `UM_SIMD_UNPACK)
      next_selected = sel_simd_unpack;
    else if (event_num_i == `EVT_SIMD_TYPE && unit_mask_i == `UM_SIMD_LOGICAL)
      next_selected = sel_simd_logical;
  end

  // Registering the selection keeps a pair that changes mid-cycle from splitting one count.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      selected <= sel_none;
    else
      selected <= next_selected;
  end

  lane_count #(
    .WIDTH(`DECODE_WIDTH),
    .CNT_W(`DECODE_CNT_W)
  ) u_decode_count (
    .lanes_i(decoded_i),
    .count_o(decoded_count)
  );

  always_comb
  begin
    simd_lanes = '0;
    case (selected)
      // Register-to-memory moves are masked out lane by lane.
      sel_simd_all: simd_lanes = simd_exec_i & ~simd_move_store_i;
      sel_simd_sat: simd_lanes = simd_saturating_i;
      sel_simd_mul: simd_lanes = simd_multiply_i;
      sel_simd_shift: simd_lanes = simd_shift_i;
      sel_simd_pack: simd_lanes = simd_pack_i;
      sel_simd_unpack: simd_lanes = simd_unpack_i;
      sel_simd_logical: simd_lanes = simd_logical_i;
      default: simd_lanes = '0;
    endcase
  end

  lane_count #(
    .WIDTH(`SIMD_WIDTH),
    .CNT_W(`SIMD_CNT_W)
  ) u_simd_count (
    .lanes_i(simd_lanes),
    .count_o(simd_count)
  );

  assign sel_simd_count = simd_count;

  always_comb
  begin
    next_increment = '0;
    case (selected)
      sel_port3: next_increment = `INC_W'(port3_dispatch_i);
      sel_port4: next_increment = `INC_W'(port4_dispatch_i);
      sel_port5: next_increment = `INC_W'(port5_dispatch_i);
      sel_decoded: next_increment = `INC_W'(decoded_count);
      // A single complex decoder means one strobe, never more than one per cycle.
      sel_complex: next_increment = `INC_W'(complex_decoded_i);
      sel_sp_sync: next_increment = `INC_W'(stack_pointer_sync_i);
      sel_sp_adds: next_increment = `INC_W'(stack_pointer_auto_add_i);
      sel_none: next_increment = '0;
      default: next_increment = `INC_W'(sel_simd_count);
    endcase
  end

  // A registered increment gives the counter one settled value per cycle, at one cycle of latency.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      increment_o <= '0;
    else
      increment_o <= next_increment;
  end

  // Valid trails the selection by one edge so that it lines up with the increment it qualifies.
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
      event_valid_o <= 1'b0;
    else
      event_valid_o <= (selected != sel_none);
  end

  sequence s_port3_hit;
    selected == sel_port3 && port3_dispatch_i;
  endsequence

  sequence s_port4_hit;
    selected == sel_port4 && port4_dispatch_i;
  endsequence

  sequence s_port_busy;
    (selected == sel_port3 && port3_dispatch_i)
    || (selected == sel_port4 && port4_dispatch_i)
    || (selected == sel_port5 && port5_dispatch_i);
  endsequence

  // Two busy cycles in a row are where an accumulating count would wrongly show two.
  sequence s_port_busy_twice;
    s_port_busy ##1 s_port_busy;
  endsequence

  chk_port3_dispatch_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_port3_hit |=> increment_o == `INC_W'(1))
    else $error("port 3 dispatch not counted");

  chk_port3_idle_zero: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_port3 && !port3_dispatch_i) |=> increment_o == '0)
    else $error("port 3 counted while idle");

  chk_port4_dispatch_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_port4_hit |=> increment_o == `INC_W'(1))
    else $error("port 4 dispatch not counted");

  chk_port5_dispatch_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_port5) |=> increment_o == `INC_W'($past(port5_dispatch_i)))
    else $error("port 5 increment mismatch");

  chk_port_single_step: assert property (
    @(posedge clock_i) disable iff (rst_i)
    s_port_busy_twice |-> (increment_o == `INC_W'(1)) ##1 (increment_o == `INC_W'(1)))
    else $error("per-port increment not one per busy cycle");

  chk_decoded_all_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_decoded) |=> increment_o == `INC_W'($countones($past(decoded_i))))
    else $error("decoded count mismatch");

  chk_complex_one_max: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_complex) |=> increment_o == `INC_W'($past(complex_decoded_i)))
    else $error("complex decode count wrong");

  chk_complex_idle_zero: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_complex && !complex_decoded_i) |=> increment_o == '0)
    else $error("complex decode counted while idle");

  chk_decoded_idle_zero: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_decoded && decoded_i == '0) |=> increment_o == '0)
    else $error("decode counted with no lanes");

  chk_sp_sync_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_sp_sync && stack_pointer_sync_i) |=> increment_o == `INC_W'(1))
    else $error("stack sync not counted");

  chk_sp_adds_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_sp_adds && !stack_pointer_auto_add_i) |=> increment_o == '0)
    else $error("stack addition counted without strobe");

  chk_sp_adds_hit: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_sp_adds && stack_pointer_auto_add_i) |=> increment_o == `INC_W'(1))
    else $error("stack addition not counted");

  chk_sp_sync_idle: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_sp_sync && !stack_pointer_sync_i) |=> increment_o == '0)
    else $error("stack sync counted without strobe");

  chk_simd_store_excluded: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_all && (simd_exec_i & ~simd_move_store_i) == '0)
    |=> increment_o == '0)
    else $error("SIMD move store counted");

  chk_simd_all_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_all)
    |=> increment_o == `INC_W'($countones($past(simd_exec_i) & ~$past(simd_move_store_i))))
    else $error("SIMD executed count mismatch");

  chk_simd_sat_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_sat)
    |=> increment_o == `INC_W'($countones($past(simd_saturating_i))))
    else $error("saturating count mismatch");

  chk_simd_mul_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_mul)
    |=> increment_o == `INC_W'($countones($past(simd_multiply_i))))
    else $error("multiply count mismatch");

  chk_simd_shift_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_shift)
    |=> increment_o == `INC_W'($countones($past(simd_shift_i))))
    else $error("shift count mismatch");

  chk_simd_pack_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_pack)
    |=> increment_o == `INC_W'($countones($past(simd_pack_i))))
    else $error("pack count mismatch");

  chk_simd_unpack_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_unpack)
    |=> increment_o == `INC_W'($countones($past(simd_unpack_i))))
    else $error("unpack count mismatch");

  chk_simd_logical_count: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected == sel_simd_logical)
    |=> increment_o == `INC_W'($countones($past(simd_logical_i))))
    else $error("logical count mismatch");

  chk_undefined_pair_idle: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (next_selected == sel_none) |=> ##1 (increment_o == '0 && !event_valid_o))
    else $error("undefined pair produced increment");

  chk_valid_follows_pair: assert property (
    @(posedge clock_i) disable iff (rst_i)
    (selected != sel_none) |=> event_valid_o)
    else $error("valid missing for defined pair");

  // Left without a disable, so that the cleared outputs are watched while reset stands.
  chk_reset_outputs_idle: assert property (
    @(posedge clock_i)
    rst_i |=> (increment_o == '0 && !event_valid_o))
    else $error("outputs not cleared by reset");
endmodule

// *** perf_event_select_decode_test.sv ***
`timescale 1ns/1ps
`include "perf_sel_defs.svh"
module perf_event_select_decode_test;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] event_num = 8'h00;
  logic [7:0] unit_mask = 8'h00;
  logic [3:0] kind = 4'h0;
  logic [2:0] lanes = 3'h0;
  logic [2:0] store = 3'h0;
  logic [2:0] st [15];
  logic [`INC_W-1:0] increment;
  logic event_valid;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  always #25 clock_i = ~clock_i;

  pipe_model partner (.kind_i(kind), .lanes_i(lanes), .store_i(store), .strobe_o(st));

  perf_event_select_decode dut (
    .clock_i(clock_i), .rst_i(rst_i), .event_num_i(event_num), .unit_mask_i(unit_mask),
    .port3_dispatch_i(st[1][0]), .port4_dispatch_i(st[2][0]), .port5_dispatch_i(st[3][0]),
    .decoded_i(st[4]), .complex_decoded_i(st[5][0]), .stack_pointer_sync_i(st[6][0]),
    .stack_pointer_auto_add_i(st[7][0]), .simd_exec_i(st[8]), .simd_move_store_i(st[0]),
    .simd_saturating_i(st[9]), .simd_multiply_i(st[10]), .simd_shift_i(st[11]),
    .simd_pack_i(st[12]), .simd_unpack_i(st[13]), .simd_logical_i(st[14]),
    .increment_o(increment), .event_valid_o(event_valid));

  task automatic close_out();
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic cmp_inc(input logic [`INC_W-1:0] exp);
    compares++;
    if (increment !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t increment got %h exp %h", $time, increment, exp);
    end
  endtask

  task automatic cmp_valid(input logic exp);
    compares++;
    if (event_valid !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t valid got %h exp %h", $time, event_valid, exp);
    end
  endtask

  // Entered at a falling edge; the pair settles one edge before the strobes arrive.
  task automatic run(input logic [7:0] ev, input logic [7:0] um, input logic [3:0] k,
    input logic [2:0] ln, input logic [2:0] sto, input logic [2:0] exp, input logic vld);
    event_num = ev;
    unit_mask = um;
    kind = 4'h0;
    @(negedge clock_i);
    kind = k;
    lanes = ln;
    store = sto;
    @(negedge clock_i);
    cmp_inc(exp);
    cmp_valid(vld);
  endtask

  task automatic scen_ports();
    run(8'hA1, 8'h08, 4'h1, 3'h7, 3'h0, 3'h1, 1'b1);
    run(8'hA1, 8'h10, 4'h2, 3'h1, 3'h0, 3'h1, 1'b1);
    run(8'hA1, 8'h08, 4'h2, 3'h1, 3'h0, 3'h0, 1'b1);
    run(8'hA1, 8'h20, 4'h3, 3'h1, 3'h0, 3'h1, 1'b1);
    @(negedge clock_i);
    cmp_inc(3'h1);
    kind = 4'h0;
    @(negedge clock_i);
    cmp_inc(3'h0);
  endtask

  task automatic scen_decode();
    run(8'hAA, 8'h01, 4'h4, 3'h7, 3'h0, 3'h3, 1'b1);
    run(8'hAA, 8'h01, 4'h4, 3'h5, 3'h0, 3'h2, 1'b1);
    run(8'hAA, 8'h08, 4'h5, 3'h7, 3'h0, 3'h1, 1'b1);
    run(8'hAB, 8'h01, 4'h6, 3'h1, 3'h0, 3'h1, 1'b1);
    run(8'hAB, 8'h01, 4'h7, 3'h1, 3'h0, 3'h0, 1'b1);
    run(8'hAB, 8'h02, 4'h7, 3'h1, 3'h0, 3'h1, 1'b1);
  endtask

  task automatic scen_simd();
    run(8'hB0, 8'h00, 4'h8, 3'h7, 3'h5, 3'h1, 1'b1);
    run(8'hB0, 8'h00, 4'hA, 3'h6, 3'h0, 3'h2, 1'b1);
    run(8'hB0, 8'h00, 4'h8, 3'h5, 3'h5, 3'h0, 1'b1);
    run(8'hB1, 8'h00, 4'h9, 3'h7, 3'h0, 3'h3, 1'b1);
    run(8'hB1, 8'h00, 4'hA, 3'h7, 3'h0, 3'h0, 1'b1);
    run(8'hB3, 8'h01, 4'hA, 3'h3, 3'h0, 3'h2, 1'b1);
    run(8'hB3, 8'h02, 4'hB, 3'h7, 3'h0, 3'h3, 1'b1);
    run(8'hB3, 8'h04, 4'hC, 3'h1, 3'h0, 3'h1, 1'b1);
    run(8'hB3, 8'h08, 4'hD, 3'h6, 3'h0, 3'h2, 1'b1);
    run(8'hB3, 8'h10, 4'hE, 3'h7, 3'h0, 3'h3, 1'b1);
  endtask

  task automatic scen_undefined();
    run(8'hB3, 8'h20, 4'hE, 3'h7, 3'h0, 3'h0, 1'b0);
    run(8'hA1, 8'h01, 4'h1, 3'h1, 3'h0, 3'h0, 1'b0);
    run(8'hAA, 8'h02, 4'h4, 3'h7, 3'h0, 3'h0, 1'b0);
    run(8'hB0, 8'h01, 4'h8, 3'h7, 3'h0, 3'h0, 1'b0);
    run(8'hAA, 8'h01, 4'h4, 3'h7, 3'h0, 3'h3, 1'b1);
    rst_i = 1'b1;
    @(negedge clock_i);
    cmp_inc(3'h0);
    cmp_valid(1'b0);
    rst_i = 1'b0;
    // The first edge after release only latches the pair, so nothing is counted yet.
    @(negedge clock_i);
    cmp_inc(3'h0);
    cmp_valid(1'b0);
    @(negedge clock_i);
    cmp_inc(3'h3);
    cmp_valid(1'b1);
  endtask

  initial
  begin
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    scen_ports();
    scen_decode();
    scen_simd();
    scen_undefined();
    close_out();
  end

  // The whole sequence needs under 100 cycles.
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      close_out();
    end
  end
endmodule

// *** perf_sel_defs.svh ***
`ifndef PERF_SEL_DEFS_SVH
`define PERF_SEL_DEFS_SVH

`define EVT_DISPATCH_PORT 8'hA1
`define EVT_DECODE 8'hAA
`define EVT_STACK_PTR 8'hAB
`define EVT_SIMD_ALL 8'hB0
`define EVT_SIMD_SAT 8'hB1
`define EVT_SIMD_TYPE 8'hB3

`define UM_NONE 8'h00
`define UM_PORT3 8'h08
`define UM_PORT4 8'h10
`define UM_PORT5 8'h20
`define UM_DECODED 8'h01
`define UM_COMPLEX 8'h08
`define UM_SP_SYNC 8'h01
`define UM_SP_ADDS 8'h02
`define UM_SIMD_MUL 8'h01
`define UM_SIMD_SHIFT 8'h02
`define UM_SIMD_PACK 8'h04
`define UM_SIMD_UNPACK 8'h08
`define UM_SIMD_LOGICAL 8'h10

`define DECODE_WIDTH 3
`define DECODE_CNT_W 2
`define SIMD_WIDTH 3
`define SIMD_CNT_W 2
`define INC_W 3

`endif

// *** perf_sel_pkg.sv ***
package perf_sel_pkg;
  typedef enum logic [3:0] {
    sel_none = 4'b0000,
    sel_port3 = 4'b0001,
    sel_port4 = 4'b0010,
    sel_port5 = 4'b0011,
    sel_decoded = 4'b0100,
    sel_complex = 4'b0101,
    sel_sp_sync = 4'b0110,
    sel_sp_adds = 4'b0111,
    sel_simd_all = 4'b1000,
    sel_simd_sat = 4'b1001,
    sel_simd_mul = 4'b1010,
    sel_simd_shift = 4'b1011,
    sel_simd_pack = 4'b1100,
    sel_simd_unpack = 4'b1101,
    sel_simd_logical = 4'b1110
  } event_sel_e;
endpackage

// *** pipe_model.sv ***
`timescale 1ns/1ps
// Stands in for the pipeline: raises the strobes of one event kind, indexed as the selections.
// Slot 0 carries the move-store lanes, which only SIMD traffic can show.
module pipe_model (
  input wire logic [3:0] kind_i,
  input wire logic [2:0] lanes_i,
  input wire logic [2:0] store_i,
  output logic [2:0] strobe_o [15]
);
  always_comb
  begin
    for (int k = 0; k < 15; k++)
    begin
      strobe_o[k] = (kind_i == 4'(k)) ? lanes_i : 3'h0;
    end
    // Ports, complex decode and stack events are single-issue, so only lane 0 is real.
    for (int k = 1; k < 8; k++)
    begin
      if (k != 4)
        strobe_o[k][2:1] = 2'h0;
    end
    // A typed SIMD op is also an executed SIMD op.
    if (kind_i >= 4'h8)
      strobe_o[8] = lanes_i;
    strobe_o[0] = (kind_i >= 4'h8) ? (store_i & lanes_i) : 3'h0;
  end
endmodule
